// >>> core/rlbs_sequencer.v
// This file holds the top sequencer with its register port and three timers.
// It assumes radio events arrive as asynchronous levels from the modem.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "rlbs_defs.vh"
module rlbs_sequencer #(
    parameter TW         = 16,
    parameter TICK_COUNT = `RLBS_TICK_CYCLES
) (
    // Clock and reset
    input  wire          clk_i,
    input  wire          reset_i,
    // Register port
    input  wire [3:0]    reg_addr_i,
    input  wire [15:0]   reg_wdata_i,
    input  wire          reg_write_i,
    input  wire          reg_read_i,
    output reg  [15:0]   reg_rdata_o,
    // Radio events
    input  wire          preamble_found_event_i,
    input  wire          sync_word_match_event_i,
    input  wire          frame_sent_event_i,
    input  wire          payload_ready_i,
    // Radio control and pins
    output reg  [2:0]    radio_mode_o,
    output reg           aux_pin_four_o,
    output reg           irq_o
);
    reg [2:0]    pf_sync;
    reg [2:0]    sw_sync;
    reg [2:0]    fs_sync;
    reg [2:0]    pr_sync;
    reg          pf_lvl;
    reg          sw_lvl;
    reg          fs_lvl;
    reg          pr_lvl;
    reg          pf_prev;
    reg          sw_prev;
    reg          fs_prev;
    reg          pr_prev;
    wire         pf_rise;
    wire         sw_rise;
    wire         fs_rise;
    wire         pr_rise;

    reg          idle_state_select;
    reg [1:0]    start_transition_select;
    reg          low_power_target_select;
    reg          idle_exit_select;
    reg [2:0]    receive_exit_select;
    reg [1:0]    rx_timeout_exit_select;
    reg          transmit_exit_select;
    reg          preamble_route_select;
    reg [1:0]    aux_four_map;
    reg [TW-1:0] wake_interval_timer;
    reg [TW-1:0] receive_window_timer;
    reg [TW-1:0] preamble_search_timeout;
    reg          sticky_irq;

    reg [2:0]    state;
    reg [2:0]    next_state;
    reg          saw_preamble;
    reg          listening;
    reg          win_done;
    reg [31:0]   tick_div;
    reg          tick;
    reg          ld_wake;
    reg          ld_win;
    reg          ld_search;
    wire         wake_exp;
    wire         win_exp;
    wire         search_exp;
    wire         start_strobe;
    wire         halt_strobe;

    assign start_strobe = reg_write_i && (reg_addr_i == `RLBS_REG_CONTROL) && reg_wdata_i[0];
    assign halt_strobe  = reg_write_i && (reg_addr_i == `RLBS_REG_CONTROL) && reg_wdata_i[1];

    // Three-stage capture; the last two stages must agree before a level changes.
    always @(posedge clk_i) begin
        if (reset_i) begin
            pf_sync <= 3'h0;
            sw_sync <= 3'h0;
            fs_sync <= 3'h0;
            pr_sync <= 3'h0;
            pf_lvl  <= 1'b0;
            sw_lvl  <= 1'b0;
            fs_lvl  <= 1'b0;
            pr_lvl  <= 1'b0;
            pf_prev <= 1'b0;
            sw_prev <= 1'b0;
            fs_prev <= 1'b0;
            pr_prev <= 1'b0;
        end else begin
            pf_sync <= {pf_sync[1:0], preamble_found_event_i};
            sw_sync <= {sw_sync[1:0], sync_word_match_event_i};
            fs_sync <= {fs_sync[1:0], frame_sent_event_i};
            pr_sync <= {pr_sync[1:0], payload_ready_i};
            if (pf_sync[1] == pf_sync[2]) pf_lvl <= pf_sync[2];
            if (sw_sync[1] == sw_sync[2]) sw_lvl <= sw_sync[2];
            if (fs_sync[1] == fs_sync[2]) fs_lvl <= fs_sync[2];
            if (pr_sync[1] == pr_sync[2]) pr_lvl <= pr_sync[2];
            pf_prev <= pf_lvl;
            sw_prev <= sw_lvl;
            fs_prev <= fs_lvl;
            pr_prev <= pr_lvl;
        end
    end
    assign pf_rise = pf_lvl & ~pf_prev;
    assign sw_rise = sw_lvl & ~sw_prev;
    assign fs_rise = fs_lvl & ~fs_prev;
    assign pr_rise = pr_lvl & ~pr_prev;

    // Slow tick standing in for the RC oscillator; it never stops, even in sleep.
    always @(posedge clk_i) begin
        if (reset_i) begin
            tick_div <= 32'h0;
            tick     <= 1'b0;
        end else if (tick_div == TICK_COUNT - 1) begin
            tick_div <= 32'h0;
            tick     <= 1'b1;
        end else begin
            tick_div <= tick_div + 32'h1;
            tick     <= 1'b0;
        end
    end

    // One tick of 64 us is the smallest wake period the timer can express.
    rlbs_timer #(.WIDTH(TW)) u_wake (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .tick_i   (tick),
        .load_i   (ld_wake),
        .period_i (wake_interval_timer),
        .expire_o (wake_exp)
    );
    rlbs_timer #(.WIDTH(TW)) u_window (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .tick_i   (tick),
        .load_i   (ld_win),
        .period_i (receive_window_timer),
        .expire_o (win_exp)
    );
    rlbs_timer #(.WIDTH(TW)) u_search (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .tick_i   (tick),
        .load_i   (ld_search),
        .period_i (preamble_search_timeout),
        .expire_o (search_exp)
    );

    // Next state; a halt write takes priority over every radio event; start only acts in off.
    always @* begin
        next_state = state;
        ld_wake    = 1'b0;
        ld_win     = 1'b0;
        ld_search  = 1'b0;
        if (halt_strobe) begin
            next_state = `RLBS_ST_OFF;
        end else begin
            case (state)
            `RLBS_ST_OFF: begin
                if (start_strobe) begin
                    case (start_transition_select)
                    `RLBS_START_TO_RX: begin
                        next_state = `RLBS_ST_RX;
                        ld_win     = 1'b1;
                        ld_search  = 1'b1;
                    end
                    `RLBS_START_TO_TX: next_state = `RLBS_ST_TX;
                    default:           next_state = `RLBS_ST_LPS;
                    endcase
                end
            end
            `RLBS_ST_LPS: begin
                if (low_power_target_select == `RLBS_LPS_TO_IDLE) begin
                    next_state = `RLBS_ST_IDLE;
                    // The wake timer waits for the window, so one cycle spans both periods.
                    ld_wake    = win_done | win_exp;
                end else begin
                    next_state = `RLBS_ST_OFF;
                end
            end
            `RLBS_ST_IDLE: begin
                if (wake_exp) begin
                    ld_win    = 1'b1;
                    ld_search = 1'b1;
                    if (idle_exit_select == `RLBS_IDLE_TO_RX) next_state = `RLBS_ST_RX;
                    else next_state = `RLBS_ST_TX;
                end else if (win_exp) begin
                    ld_wake = 1'b1;
                end
            end
            `RLBS_ST_RX: begin
                if (receive_exit_select == `RLBS_RXX_ON_PREAMBLE && pf_rise) begin
                    next_state = `RLBS_ST_OFF;
                end else if (receive_exit_select == `RLBS_RXX_ON_SYNC && sw_rise) begin
                    next_state = `RLBS_ST_OFF;
                end else if (receive_exit_select == `RLBS_RXX_ON_SYNC &&
                             search_exp && !saw_preamble) begin
                    case (rx_timeout_exit_select)
                    `RLBS_RXT_TO_LPS: next_state = `RLBS_ST_LPS;
                    `RLBS_RXT_TO_TX:  next_state = `RLBS_ST_TX;
                    `RLBS_RXT_TO_OFF: next_state = `RLBS_ST_OFF;
                    default: begin
                        ld_win    = 1'b1;
                        ld_search = 1'b1;
                    end
                    endcase
                end else if (win_exp) begin
                    next_state = `RLBS_ST_LPS;
                end
            end
            `RLBS_ST_TX: begin
                if (fs_rise) begin
                    if (transmit_exit_select == `RLBS_TXX_TO_LPS) begin
                        next_state = `RLBS_ST_LPS;
                    end else begin
                        next_state = `RLBS_ST_RX;
                        ld_win     = 1'b1;
                        ld_search  = 1'b1;
                    end
                end
            end
            default: next_state = `RLBS_ST_OFF;
            endcase
        end
    end

    // State, radio mode and flags; after a stop the last radio mode simply holds.
    always @(posedge clk_i) begin
        if (reset_i) begin
            state        <= `RLBS_ST_OFF;
            radio_mode_o <= `RLBS_MODE_STANDBY;
            saw_preamble <= 1'b0;
            listening    <= 1'b0;
            win_done     <= 1'b1;
        end else begin
            state <= next_state;
            if (ld_win) win_done <= 1'b0;
            else if (win_exp) win_done <= 1'b1;
            if (next_state == `RLBS_ST_RX && state != `RLBS_ST_RX) saw_preamble <= 1'b0;
            else if (state == `RLBS_ST_RX && pf_rise) saw_preamble <= 1'b1;
            if (next_state != `RLBS_ST_OFF) listening <= 1'b1;
            else if (state != `RLBS_ST_RX || halt_strobe) listening <= 1'b0;
            case (next_state)
            `RLBS_ST_RX:   radio_mode_o <= `RLBS_MODE_RX;
            `RLBS_ST_TX:   radio_mode_o <= `RLBS_MODE_TX;
            `RLBS_ST_IDLE: radio_mode_o <= idle_state_select ?
                                           `RLBS_MODE_SLEEP : `RLBS_MODE_STANDBY;
            `RLBS_ST_LPS:  radio_mode_o <= radio_mode_o;
            default:       radio_mode_o <= (state == `RLBS_ST_RX && !halt_strobe) ?
                                           `RLBS_MODE_RX : radio_mode_o;
            endcase
        end
    end

    // Registers, pin routing and the sticky packet request; a new packet wins over a clear.
    always @(posedge clk_i) begin
        if (reset_i) begin
            idle_state_select       <= 1'b0;
            start_transition_select <= 2'h0;
            low_power_target_select <= 1'b0;
            idle_exit_select        <= 1'b0;
            receive_exit_select     <= 3'h0;
            rx_timeout_exit_select  <= 2'h0;
            transmit_exit_select    <= 1'b0;
            preamble_route_select   <= 1'b0;
            aux_four_map            <= 2'h0;
            wake_interval_timer     <= {{(TW-1){1'b0}}, 1'b1};
            receive_window_timer    <= {{(TW-1){1'b0}}, 1'b1};
            preamble_search_timeout <= {{(TW-1){1'b0}}, 1'b1};
            sticky_irq              <= 1'b0;
            reg_rdata_o             <= 16'h0000;
            aux_pin_four_o          <= 1'b0;
            irq_o                   <= 1'b0;
        end else begin
            if (reg_write_i) begin
                case (reg_addr_i)
                `RLBS_REG_SELECT: begin
                    idle_state_select       <= reg_wdata_i[0];
                    start_transition_select <= reg_wdata_i[2:1];
                    low_power_target_select <= reg_wdata_i[3];
                    idle_exit_select        <= reg_wdata_i[4];
                    receive_exit_select     <= reg_wdata_i[7:5];
                    rx_timeout_exit_select  <= reg_wdata_i[9:8];
                    transmit_exit_select    <= reg_wdata_i[10];
                end
                `RLBS_REG_WAKE:   wake_interval_timer     <= reg_wdata_i[TW-1:0];
                `RLBS_REG_WINDOW: receive_window_timer    <= reg_wdata_i[TW-1:0];
                `RLBS_REG_SEARCH: preamble_search_timeout <= reg_wdata_i[TW-1:0];
                `RLBS_REG_PINS: begin
                    aux_four_map          <= reg_wdata_i[1:0];
                    preamble_route_select <= reg_wdata_i[2];
                end
                default: ;
                endcase
            end
            if (listening && pr_rise) sticky_irq <= 1'b1;
            else if (reg_write_i && reg_addr_i == `RLBS_REG_STATUS && reg_wdata_i[0])
                sticky_irq <= 1'b0;
            irq_o <= sticky_irq;
            aux_pin_four_o <= (aux_four_map == `RLBS_MAP_PREAMBLE) &&
                              preamble_route_select && pf_lvl;
            reg_rdata_o <= 16'h0000;
            if (reg_read_i) begin
                case (reg_addr_i)
                `RLBS_REG_SELECT: reg_rdata_o <= {5'h00, transmit_exit_select,
                    rx_timeout_exit_select, receive_exit_select, idle_exit_select,
                    low_power_target_select, start_transition_select, idle_state_select};
                `RLBS_REG_WAKE:   reg_rdata_o <= wake_interval_timer;
                `RLBS_REG_WINDOW: reg_rdata_o <= receive_window_timer;
                `RLBS_REG_SEARCH: reg_rdata_o <= preamble_search_timeout;
                `RLBS_REG_STATUS: reg_rdata_o <= {9'h000, radio_mode_o, state, sticky_irq};
                `RLBS_REG_PINS:   reg_rdata_o <= {13'h0000, preamble_route_select, aux_four_map};
                default:          reg_rdata_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule // rlbs_sequencer

// >>> core/rlbs_defs.vh
// Constants of the listen and beacon sequencer: selector codes, states and timing.
// Assumes inclusion by its bare name from the sequencer design files.
`ifndef RLBS_DEFS_VH
`define RLBS_DEFS_VH
`define RLBS_CLK_MHZ          250
`define RLBS_TICK_US          64
`define RLBS_TICK_CYCLES      (`RLBS_TICK_US * `RLBS_CLK_MHZ)
`define RLBS_START_TO_LPS     2'h0
`define RLBS_START_TO_RX      2'h1
`define RLBS_START_TO_TX      2'h2
`define RLBS_LPS_TO_OFF       1'h0
`define RLBS_LPS_TO_IDLE      1'h1
`define RLBS_IDLE_TO_TX       1'h0
`define RLBS_IDLE_TO_RX       1'h1
`define RLBS_RXX_ON_SYNC      3'h5
`define RLBS_RXX_ON_PREAMBLE  3'h6
`define RLBS_RXT_TO_RX        2'h0
`define RLBS_RXT_TO_TX        2'h1
`define RLBS_RXT_TO_LPS       2'h2
`define RLBS_RXT_TO_OFF       2'h3
`define RLBS_TXX_TO_LPS       1'h0
`define RLBS_TXX_TO_RX        1'h1
`define RLBS_MAP_PREAMBLE     2'h3
`define RLBS_MODE_SLEEP       3'h0
`define RLBS_MODE_STANDBY     3'h1
`define RLBS_MODE_TX          3'h3
`define RLBS_MODE_RX          3'h5
`define RLBS_REG_CONTROL      4'h0
`define RLBS_REG_SELECT       4'h1
`define RLBS_REG_WAKE         4'h2
`define RLBS_REG_WINDOW       4'h3
`define RLBS_REG_SEARCH       4'h4
`define RLBS_REG_STATUS       4'h5
`define RLBS_REG_PINS         4'h6
`define RLBS_ST_OFF           3'h0
`define RLBS_ST_IDLE          3'h1
`define RLBS_ST_RX            3'h2
`define RLBS_ST_TX            3'h3
`define RLBS_ST_LPS           3'h4
`endif

// >>> core/rlbs_timer.v
// One down-counting sequencer timer measured in slow oscillator ticks.
// Assumes the tick enable is one clock cycle long and the clock is clk_i.
`timescale 1ns/10ps
`include "rlbs_defs.vh"
module rlbs_timer #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             reset_i,
    // Control
    input  wire             tick_i,
    input  wire             load_i,
    input  wire [WIDTH-1:0] period_i,
    // Result
    output reg              expire_o
);
    reg [WIDTH-1:0] count;
    reg             running;

    // Expiry after period ticks; a zero period is treated as one tick so it always ends.
    always @(posedge clk_i) begin
        expire_o <= 1'b0;
        if (reset_i) begin
            count   <= {WIDTH{1'b0}};
            running <= 1'b0;
        end else if (load_i) begin
            count   <= (period_i == {WIDTH{1'b0}}) ? {{(WIDTH-1){1'b0}}, 1'b1} : period_i;
            running <= 1'b1;
        end else if (running && tick_i) begin
            if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                running  <= 1'b0;
                expire_o <= 1'b1;
            end
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // rlbs_timer

// >>> testbench/rlbs_sequencer_checker.sv
// Port checker of the listen and beacon sequencer.
// Assumes a bind to rlbs_sequencer and receive windows of at most WIN ticks.
`timescale 1ns/10ps
`include "rlbs_defs.vh"
module rlbs_checker #(
    parameter TICK_COUNT = 4,
    parameter WIN        = 6
) (
    // Clock
    input wire        clk_i,
    input wire        reset_i,
    // Registers
    input wire [3:0]  reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire        reg_write_i,
    input wire        reg_read_i,
    input wire [15:0] reg_rdata_o,
    // Radio
    input wire        preamble_found_event_i,
    input wire        sync_word_match_event_i,
    input wire        frame_sent_event_i,
    input wire        payload_ready_i,
    input wire [2:0]  radio_mode_o,
    input wire        aux_pin_four_o,
    input wire        irq_o
);
    // Slack covers the tick phase and the event synchroniser.
    localparam LIMIT = (WIN + 2) * TICK_COUNT + 8;
    reg [15:0] quiet;
    always @(posedge clk_i) begin
        if (reset_i || radio_mode_o != `RLBS_MODE_RX || preamble_found_event_i) begin
            quiet <= 16'h0000;
        end else begin
            quiet <= quiet + 16'h0001;
        end
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence status_rd;
        reg_read_i && reg_addr_i == `RLBS_REG_STATUS;
    endsequence
    sequence halt_wr;
        reg_write_i && reg_addr_i == `RLBS_REG_CONTROL && reg_wdata_i[1];
    endsequence
    a_rdata_quiet: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property (reg_read_i && reg_addr_i > `RLBS_REG_PINS |=> !reg_rdata_o)
        else $error("unmapped read not zero");
    a_status_mode: assert property (status_rd |=> reg_rdata_o[6:4] == $past(radio_mode_o))
        else $error("status mode field wrong");
    a_sleep_exit: assert property ($past(radio_mode_o) == `RLBS_MODE_SLEEP && radio_mode_o !=
        `RLBS_MODE_SLEEP |-> radio_mode_o == `RLBS_MODE_RX || radio_mode_o == `RLBS_MODE_TX)
        else $error("sleep left to a wrong mode");
    a_tx_exit: assert property ($past(radio_mode_o) == `RLBS_MODE_TX && radio_mode_o !=
        `RLBS_MODE_TX |-> $past(frame_sent_event_i)) else $error("transmit left early");
    a_rx_bound: assert property (quiet <= LIMIT)
        else $error("receive window too long");
    a_aux_cause: assert property ($rose(aux_pin_four_o) |-> $past(preamble_found_event_i, 3))
        else $error("aux pin rose without preamble");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(payload_ready_i, 3))
        else $error("irq rose without packet");
    a_halt_hold: assert property (halt_wr |=> $stable(radio_mode_o) [*6])
        else $error("mode moved after halt");
    a_reset_state: assert property ($fell(reset_i) |->
        radio_mode_o == `RLBS_MODE_STANDBY && !irq_o && !aux_pin_four_o)
        else $error("wrong outputs after reset");
endmodule // rlbs_checker
bind rlbs_sequencer rlbs_checker #(.TICK_COUNT(TICK_COUNT), .WIN(6)) i_rlbs_checker (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .preamble_found_event_i(preamble_found_event_i),
    .sync_word_match_event_i(sync_word_match_event_i),
    .frame_sent_event_i(frame_sent_event_i), .payload_ready_i(payload_ready_i),
    .radio_mode_o(radio_mode_o), .aux_pin_four_o(aux_pin_four_o), .irq_o(irq_o));

// >>> testbench/rlbs_modem_model.sv
// Behavioural radio modem that raises event levels while receiving or sending.
// Assumes the bench sets the commands; levels drop as soon as the mode moves on.
`timescale 1ns/10ps
`include "rlbs_defs.vh"
module rlbs_modem_model (
    // Clock
    input  wire       clk_i,
    input  wire       reset_i,
    // Commands
    input  wire       send_pre_i,
    input  wire       send_sync_i,
    input  wire [2:0] radio_mode_i,
    // Events
    output reg        pre_o  = 1'b0,
    output reg        sync_o = 1'b0,
    output reg        sent_o = 1'b0,
    output reg        pay_o  = 1'b0
);
    reg  [7:0] age;
    wire       rx = radio_mode_i == `RLBS_MODE_RX;
    wire       tx = radio_mode_i == `RLBS_MODE_TX;
    always @(posedge clk_i) begin
        if (reset_i || !(rx || tx)) begin
            age <= 8'h00;
        end else if (age != 8'hFF) begin
            age <= age + 8'h01;
        end
        // The preamble lasts the whole receive period, longer than any window.
        pre_o  <= rx && send_pre_i && age >= 8'h01;
        sync_o <= rx && send_sync_i && age >= 8'h0A;
        pay_o  <= rx && send_sync_i && age >= 8'h0A && age < 8'h16;
        // Every beacon is the same short frame, so each one ends alike.
        sent_o <= tx && age >= 8'h06;
    end
endmodule // rlbs_modem_model

// >>> testbench/test_radio_listen_beacon_sequencer.sv
// Self-checking bench of the listen and beacon sequencer beside a modem model.
// Assumes the design, its checker and the modem model are compiled first.
`timescale 1ns/10ps
`include "rlbs_defs.vh"
module test_radio_listen_beacon_sequencer;
    reg         clk_i       = 1'b0;
    reg         reset_i     = 1'b1;
    reg  [3:0]  reg_addr_i  = 4'h0;
    reg  [15:0] reg_wdata_i = 16'h0000;
    reg         reg_write_i = 1'b0;
    reg         reg_read_i  = 1'b0;
    reg         send_pre    = 1'b0;
    reg         send_sync   = 1'b0;
    reg         rd_pend     = 1'b0;
    reg  [15:0] v;
    reg  [3:0]  a;
    reg  [15:0] exp_q[$];
    wire [15:0] reg_rdata_o;
    wire [2:0]  radio_mode_o;
    wire        pre_ev, sync_ev, sent_ev, pay_ev, aux_pin_four_o, irq_o;
    integer     failures    = 0;
    integer     check_count = 0;
    integer     seed        = 32'h6742;
    integer     n, k, len;
    always #2 clk_i = ~clk_i;
    rlbs_sequencer #(.TW(16), .TICK_COUNT(4)) i_rlbs_sequencer (
        .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
        .preamble_found_event_i(pre_ev), .sync_word_match_event_i(sync_ev),
        .frame_sent_event_i(sent_ev), .payload_ready_i(pay_ev), .radio_mode_o(radio_mode_o),
        .aux_pin_four_o(aux_pin_four_o), .irq_o(irq_o));
    rlbs_modem_model i_rlbs_modem_model (
        .clk_i(clk_i), .reset_i(reset_i), .send_pre_i(send_pre), .send_sync_i(send_sync),
        .radio_mode_i(radio_mode_o), .pre_o(pre_ev), .sync_o(sync_ev), .sent_o(sent_ev),
        .pay_o(pay_ev));
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input [15:0] got, input [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Read data stand one cycle only, so the watcher samples them mid-cycle.
    always @(posedge clk_i) rd_pend <= reg_read_i;
    always @(negedge clk_i) begin
        if (rd_pend) begin
            chk(reg_rdata_o, exp_q.pop_front());
        end
    end
    task wr(input [3:0] ad, input [15:0] d);
        @(posedge clk_i);
        reg_addr_i  <= ad;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task rd(input [3:0] ad, input [15:0] e);
        exp_q.push_back(e);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task wait_mode(input [2:0] m, input integer lim);
        n = 0;
        while (radio_mode_o !== m && n < lim) begin
            @(negedge clk_i);
            n = n + 1;
        end
        check_count = check_count + 1;
        if (n >= lim) begin
            failures = failures + 1;
            $display("MISMATCH %0t mode %h not reached", $time, m);
            complete_run;
        end
    endtask
    task do_reset;
        @(posedge clk_i);
        send_pre  <= 1'b0;
        send_sync <= 1'b0;
        reset_i   <= 1'b1;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
    endtask
    task setup(input [15:0] sel, input [15:0] wk, input [15:0] win, input [15:0] pins);
        do_reset;
        wr(`RLBS_REG_SELECT, sel);
        wr(`RLBS_REG_WAKE, wk);
        wr(`RLBS_REG_WINDOW, win);
        wr(`RLBS_REG_SEARCH, 16'h0003);
        wr(`RLBS_REG_PINS, pins);
        wr(`RLBS_REG_CONTROL, 16'h0001);
    endtask
    initial begin
        do_reset;
        rd(`RLBS_REG_STATUS, 16'h0010);
        rd(`RLBS_REG_WAKE, 16'h0001);
        rd(`RLBS_REG_SEARCH, 16'h0001);
        v = $random(seed);
        wr(`RLBS_REG_WAKE, v);
        rd(`RLBS_REG_WAKE, v);
        repeat (4) begin
            a = 4'h7 + 4'($unsigned($random(seed)) % 9);
            wr(a, 16'hFFFF);
            rd(a, 16'h0000);
        end
        rd(`RLBS_REG_WAKE, v);
        $display("Test registers done");
        setup(16'h02D9, 16'h0002, 16'h0003, 16'h0007);
        wait_mode(`RLBS_MODE_SLEEP, 40);
        rd(`RLBS_REG_STATUS, 16'h0002);
        wait_mode(`RLBS_MODE_RX, 60);
        wait_mode(`RLBS_MODE_SLEEP, 40);
        len = n;
        chk({15'h0000, len >= 7 && len <= 17}, 16'h0001);
        wait_mode(`RLBS_MODE_RX, 40);
        chk({15'h0000, len + n >= 11 && len + n <= 29}, 16'h0001);
        send_pre <= 1'b1;
        repeat (40) @(negedge clk_i);
        rd(`RLBS_REG_STATUS, 16'h0050);
        chk({15'h0000, aux_pin_four_o}, 16'h0001);
        repeat (100) @(negedge clk_i);
        rd(`RLBS_REG_STATUS, 16'h0050);
        $display("Test wake on preamble done");
        setup(16'h02B9, 16'h0001, 16'h0006, 16'h0004);
        wait_mode(`RLBS_MODE_RX, 80);
        wait_mode(`RLBS_MODE_SLEEP, 40);
        chk({15'h0000, n <= 18}, 16'h0001);
        len = n;
        send_pre <= 1'b1;
        wait_mode(`RLBS_MODE_RX, 40);
        chk({15'h0000, len + n >= 23 && len + n <= 33}, 16'h0001);
        wait_mode(`RLBS_MODE_SLEEP, 60);
        chk({15'h0000, n >= 19}, 16'h0001);
        send_sync <= 1'b1;
        wait_mode(`RLBS_MODE_RX, 40);
        repeat (40) @(negedge clk_i);
        rd(`RLBS_REG_STATUS, 16'h0051);
        chk({15'h0000, irq_o}, 16'h0001);
        chk({15'h0000, aux_pin_four_o}, 16'h0000);
        wr(`RLBS_REG_STATUS, 16'h0001);
        rd(`RLBS_REG_STATUS, 16'h0050);
        chk({15'h0000, irq_o}, 16'h0000);
        $display("Test wake on sync done");
        setup(16'h0009, 16'h0002, 16'h0003, 16'h0000);
        for (k = 0; k < 3; k = k + 1) begin
            wait_mode(`RLBS_MODE_TX, 80);
            wait_mode(`RLBS_MODE_SLEEP, 40);
        end
        wr(`RLBS_REG_CONTROL, 16'h0002);
        rd(`RLBS_REG_STATUS, 16'h0000);
        repeat (80) @(negedge clk_i);
        chk({13'h0000, radio_mode_o}, {13'h0000, `RLBS_MODE_SLEEP});
        $display("Test beacon done");
        complete_run;
    end
endmodule // test_radio_listen_beacon_sequencer
